// file: hdl/drive_command_word_decoder.sv
// command word decoder with an ahb-lite register slave
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "cmd_word_defs.svh"
// How it works
// - 32-bit interface, command split into two words
// - stop uses configured mode or request bits
// - start plus stop together means stop
// - direction is reverse bit xor reference sign
// - bit 3 picks local or external control
// - bit 5 picks external location b or a
// - bit 7 stops along selected ramp, needs stop
// - bit 8 emergency stop, needs stop
// - bit 9 coast stop, needs stop
// - bit 10 selects second ramp pair
// - bit 11 forces ramp output to zero
// - bit 12 holds ramp output
// - bit 13 forces ramp input to zero
// - bit 14 locks out panel local request
// - bit 15 selects second torque limit set
module drive_command_word_decoder (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // reference sign from the upper command word
  input wire logic reference_sign,
  // panel key asking for local control
  input wire logic panel_local_key,
  // drive commands
  output logic run_command,
  output logic stop_active,
  output cmd_word_pkg::stop_mode_t stop_mode,
  output logic reverse_direction,
  output logic local_control,
  output logic external_location_a,
  output logic external_location_b,
  output logic fault_reset_pulse,
  output logic run_disable,
  output logic ramp_pair_two,
  output logic ramp_output_zero,
  output logic ramp_output_hold,
  output logic ramp_input_zero,
  output logic panel_local_lockout,
  output logic second_torque_limit_select
);
  logic [15:0] drive_command_word_low;
  cmd_word_pkg::stop_mode_t config_stop_mode;
  cmd_word_pkg::run_state_t run_state;
  cmd_word_pkg::run_state_t next_run_state;
  cmd_word_pkg::stop_mode_t next_stop_mode;
  logic prev_reset_bit;
  logic wr_pending;
  logic [11:0] wr_addr;
  logic access;

  // one-cycle address phase; the slave never inserts wait states
  assign access = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // write strobes for the data phase; writes to unmapped offsets are dropped quietly
  logic cw_low_write;
  logic config_write;
  logic [31:0] next_hrdata;
  logic [31:0] cw_low_read;
  logic [31:0] status_read;
  logic [31:0] config_read;
  assign cw_low_write = wr_pending && wr_addr == `CW_LOW_OFFSET;
  assign config_write = wr_pending && wr_addr == `CW_CONFIG_OFFSET;

  // read words; the upper half of the command word is not kept here and reads 0
  assign cw_low_read = {16'h0000, drive_command_word_low};
  assign status_read = {28'h0000000, stop_mode, stop_active, run_command};
  assign config_read = {30'h00000000, config_stop_mode};

  // remember that a write was accepted in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_pending <= 1'b0;
    else
      wr_pending <= access && hwrite;
  end

  // address of the last phase; loaded every cycle, only trusted while wr_pending
  // saves an enable on twelve flops, since the strobe qualifies it anyway
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_addr <= 12'h000;
    else
      wr_addr <= haddr;
  end

  // command word: only the low half lives here, the upper word is elsewhere
  // the upper sixteen data bits are ignored rather than refused
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      drive_command_word_low <= `CW_LOW_RESET;
    else if (cw_low_write)
      drive_command_word_low <= hwdata[15:0];
  end

  // configured stop mode used when stop carries no mode request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      config_stop_mode <= cmd_word_pkg::stop_mode_t'(`CW_CONFIG_RESET);
    else if (config_write)
      config_stop_mode <= cmd_word_pkg::stop_mode_t'(hwdata[1:0]);
  end

  // read data select by the address of the phase
  always_comb
  begin
    next_hrdata = 32'h00000000;
    unique case (haddr)
      `CW_LOW_OFFSET: next_hrdata = cw_low_read;
      `CW_STATUS_OFFSET: next_hrdata = status_read;
      `CW_CONFIG_OFFSET: next_hrdata = config_read;
      default: next_hrdata = 32'h00000000;
    endcase
  end

  // read data registered at the address phase so it stands in the data phase
  // this costs no wait state, so hreadyout can stay tied high
  // hrdata holds until the next read, idle cycles leave it alone
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (access && !hwrite)
      hrdata <= next_hrdata;
  end

  // stop mode from the request bits
  stop_mode_select u_stop_mode (
    .stop_bit(drive_command_word_low[`CW_BIT_STOP]),
    .stop_by_ramp_request(drive_command_word_low[`CW_BIT_STOP_RAMP]),
    .emergency_halt_request(drive_command_word_low[`CW_BIT_STOP_EMERG]),
    .coast_halt_request(drive_command_word_low[`CW_BIT_STOP_COAST]),
    .config_mode(config_stop_mode),
    .mode(next_stop_mode)
  );

  // start/stop decode; stop wins over a simultaneous start
  always_comb
  begin
    next_run_state = run_state;
    unique case (run_state)
      cmd_word_pkg::st_idle:
        if (drive_command_word_low[`CW_BIT_START] && !drive_command_word_low[`CW_BIT_STOP]
            && !drive_command_word_low[`CW_BIT_RUN_DIS])
          next_run_state = cmd_word_pkg::st_run;
      cmd_word_pkg::st_run:
        if (drive_command_word_low[`CW_BIT_STOP] || drive_command_word_low[`CW_BIT_RUN_DIS])
          next_run_state = cmd_word_pkg::st_idle;
      default: next_run_state = cmd_word_pkg::st_idle;
    endcase
  end

  // run state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run_state <= cmd_word_pkg::st_idle;
    else
      run_state <= next_run_state;
  end

  // run output follows the next state so it moves with the state register
  // a separate decode of run_state would lag one more cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run_command <= 1'b0;
    else
      run_command <= next_run_state == cmd_word_pkg::st_run;
  end

  // stop level as written; it stands as long as the master holds the bit
  // the drive side decides how long a stop takes, not this block
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stop_active <= 1'b0;
    else
      stop_active <= drive_command_word_low[`CW_BIT_STOP];
  end

  // stop mode tracks the word, so it is ready in the cycle the stop lands
  // without stop the configured mode shows, since requests alone count for nothing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stop_mode <= cmd_word_pkg::stop_by_config;
    else
      stop_mode <= next_stop_mode;
  end

  // last seen reset bit, for the edge detector below
  // resets low so a word written with the bit set still gives one pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prev_reset_bit <= 1'b0;
    else
      prev_reset_bit <= drive_command_word_low[`CW_BIT_RESET];
  end

  // fault reset on a rising edge of the reset bit only
  // a held bit must not keep clearing faults that come back
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fault_reset_pulse <= 1'b0;
    else
      fault_reset_pulse <= drive_command_word_low[`CW_BIT_RESET] && !prev_reset_bit;
  end

  // direction; the sign input is taken as settled with the word
  // a sign change alone flips the direction, with no write needed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reverse_direction <= 1'b0;
    else
      reverse_direction <= drive_command_word_low[`CW_BIT_REVERSE] ^ reference_sign;
  end

  // panel key may only push to local when not locked out
  // the word's own local bit is never locked out, only the panel key
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      local_control <= 1'b0;
    else
      local_control <= drive_command_word_low[`CW_BIT_LOCAL]
        || (panel_local_key && !drive_command_word_low[`CW_BIT_LOCKOUT]);
  end

  // external location a, the default after reset
  // a and b are kept as two flops so they are never both seen low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      external_location_a <= 1'b1;
    else
      external_location_a <= !drive_command_word_low[`CW_BIT_LOC_B];
  end

  // external location b
  // driven from the same bit as a, so the pair switches in one edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      external_location_b <= 1'b0;
    else
      external_location_b <= drive_command_word_low[`CW_BIT_LOC_B];
  end

  // run disable level
  // the run state machine also drops out of run on this bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run_disable <= 1'b0;
    else
      run_disable <= drive_command_word_low[`CW_BIT_RUN_DIS];
  end

  // ramp pair select, also picks the ramp a ramp stop follows
  // changing it during a ramp stop changes that stop's slope at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ramp_pair_two <= 1'b0;
    else
      ramp_pair_two <= drive_command_word_low[`CW_BIT_RAMP_PAIR];
  end

  // ramp output forced to zero
  // passed as a level; priority against hold is the ramp's business
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ramp_output_zero <= 1'b0;
    else
      ramp_output_zero <= drive_command_word_low[`CW_BIT_RAMP_OUT0];
  end

  // ramp output held at its present value
  // no latching here, the ramp itself keeps the frozen value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ramp_output_hold <= 1'b0;
    else
      ramp_output_hold <= drive_command_word_low[`CW_BIT_RAMP_HOLD];
  end

  // ramp input forced to zero
  // the ramp then runs down on its own slope, unlike the output force
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ramp_input_zero <= 1'b0;
    else
      ramp_input_zero <= drive_command_word_low[`CW_BIT_RAMP_IN0];
  end

  // panel lockout shown outside as well as used for local_control
  // the panel may want to show why its key does nothing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      panel_local_lockout <= 1'b0;
    else
      panel_local_lockout <= drive_command_word_low[`CW_BIT_LOCKOUT];
  end

  // torque limit set select
  // the first set applies after reset, before any word is written
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      second_torque_limit_select <= 1'b0;
    else
      second_torque_limit_select <= drive_command_word_low[`CW_BIT_TORQ2];
  end
endmodule

// file: hdl/cmd_word_defs.svh
// offsets, field positions and reset values of the command word decoder
`ifndef CMD_WORD_DEFS_SVH
`define CMD_WORD_DEFS_SVH
`define CW_LOW_OFFSET 12'h000
`define CW_STATUS_OFFSET 12'h004
`define CW_CONFIG_OFFSET 12'h008
`define CW_LOW_RESET 16'h0000
`define CW_CONFIG_RESET 2'h0
`define CW_BIT_STOP 0
`define CW_BIT_START 1
`define CW_BIT_REVERSE 2
`define CW_BIT_LOCAL 3
`define CW_BIT_RESET 4
`define CW_BIT_LOC_B 5
`define CW_BIT_RUN_DIS 6
`define CW_BIT_STOP_RAMP 7
`define CW_BIT_STOP_EMERG 8
`define CW_BIT_STOP_COAST 9
`define CW_BIT_RAMP_PAIR 10
`define CW_BIT_RAMP_OUT0 11
`define CW_BIT_RAMP_HOLD 12
`define CW_BIT_RAMP_IN0 13
`define CW_BIT_LOCKOUT 14
`define CW_BIT_TORQ2 15
`endif

// file: hdl/cmd_word_pkg.sv
// types shared by the command word decoder
package cmd_word_pkg;
  // how the motor is brought to rest
  typedef enum logic [1:0] {
    stop_by_config = 2'h0,
    stop_by_ramp = 2'h1,
    stop_emergency = 2'h2,
    stop_coast = 2'h3
  } stop_mode_t;
  // run state of the start/stop decoder, one-hot
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_run = 2'h2
  } run_state_t;
endpackage

// file: hdl/stop_mode_select.sv
// chooses the stop mode from the request bits or the configured setting
`timescale 1ns/1ns
`include "cmd_word_defs.svh"
module stop_mode_select (
  // command word bits
  input wire logic stop_bit,
  input wire logic stop_by_ramp_request,
  input wire logic emergency_halt_request,
  input wire logic coast_halt_request,
  // configured setting used when no request is made
  input wire cmd_word_pkg::stop_mode_t config_mode,
  // chosen mode
  output cmd_word_pkg::stop_mode_t mode
);
  // requests only count together with stop; emergency outranks coast, coast outranks ramp
  always_comb
  begin
    mode = config_mode;
    if (stop_bit && emergency_halt_request)
      mode = cmd_word_pkg::stop_emergency;
    else if (stop_bit && coast_halt_request)
      mode = cmd_word_pkg::stop_coast;
    else if (stop_bit && stop_by_ramp_request)
      mode = cmd_word_pkg::stop_by_ramp;
  end
endmodule

// file: verification/cwd_sva.sv
// assertion checker for the command word decoder ports
`timescale 1ns/1ns
module cwd_sva (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // commands
  input wire logic reference_sign,
  input wire logic run_command,
  input wire cmd_word_pkg::stop_mode_t stop_mode,
  input wire logic reverse_direction,
  input wire logic local_control,
  input wire logic external_location_b,
  input wire logic fault_reset_pulse,
  input wire logic run_disable
);
  logic wr_pend;
  logic [15:0] cw;
  // shadow word, loaded at the write's data-phase edge like the real one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      cw <= 16'h0000;
    end
    else
    begin
      if (wr_pend)
        cw <= hwdata[15:0];
      wr_pend <= hsel && hready && htrans[1] && hwrite && haddr == 12'h000;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_reset_rise;
    $rose(cw[4]);
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  AST_DIRECTION: assert property (reverse_direction == ($past(cw[2]) ^ $past(reference_sign)))
    else $error("direction wrong");
  AST_LOCATION_B: assert property (external_location_b == $past(cw[5]))
    else $error("location select wrong");
  AST_LOCAL: assert property ($past(cw[3]) |-> local_control)
    else $error("local mode missing");
  AST_RUN_DISABLE: assert property (run_disable == $past(cw[6]))
    else $error("run disable wrong");
  AST_STOP_WINS: assert property ($past(cw[0]) |-> !run_command)
    else $error("runs while stop set");
  AST_MODE_EMERG: assert property ($past(cw[0]) && $past(cw[8]) |-> stop_mode == 2'h2)
    else $error("emergency mode missing");
  AST_MODE_RAMP: assert property ($past(cw[0]) && $past(cw[9:7]) == 3'h1 |-> stop_mode == 2'h1)
    else $error("ramp mode missing");
  AST_FAULT_PULSE: assert property (s_reset_rise |=> fault_reset_pulse ##1 !fault_reset_pulse)
    else $error("fault reset pulse not single");
  AST_FAULT_ONLY: assert property (fault_reset_pulse |-> $past(cw[4]) && !$past(cw[4], 2))
    else $error("fault reset without rise");
endmodule

// file: verification/cwd_master.sv
// bus master model standing in for the fieldbus controller
`timescale 1ns/1ns
module cwd_master (
  // clock
  input wire logic hclk,
  // request
  output logic hsel = 1'b0,
  output logic [11:0] haddr = 12'h000,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0,
  // answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // one single word transfer; waits are bounded so a stuck slave ends the run
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready && n < 50)
    begin
      @(posedge hclk);
      n++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready && n < 50)
    begin
      @(posedge hclk);
      n++;
    end
    q = hrdata;
    hwdata <= ~d; // released data must not look valid
    ok = n < 50;
  endtask
endmodule

// file: verification/drive_command_word_decoder_tb.sv
// self-checking bench for the command word decoder
`timescale 1ns/1ns
module drive_command_word_decoder_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic reference_sign = 1'b0;
  logic panel_local_key = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, ok;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic run_command, stop_active, reverse_direction, local_control, external_location_a;
  logic external_location_b, fault_reset_pulse, run_disable, ramp_pair_two, ramp_output_zero;
  logic ramp_output_hold, ramp_input_zero, panel_local_lockout, second_torque_limit_select;
  cmd_word_pkg::stop_mode_t stop_mode;
  logic [15:0] outs, w, p, e;
  logic [19:0] tv [8] = '{20'h00021, 20'h00032, 20'h00836, 20'h0183a, 20'h0383a,
    20'h0283e, 20'h02021, 20'h0001e};
  int err_total = 0;
  int tests_run = 0;
  assign outs = {run_command, stop_mode, second_torque_limit_select, panel_local_lockout,
    ramp_input_zero, ramp_output_hold, ramp_output_zero, ramp_pair_two, run_disable,
    external_location_b, external_location_a, local_control, reverse_direction, stop_active,
    fault_reset_pulse};
  always #5 hclk = ~hclk;
  cwd_master u_master (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  drive_command_word_decoder u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .reference_sign(reference_sign), .panel_local_key(panel_local_key),
    .run_command(run_command), .stop_active(stop_active), .stop_mode(stop_mode),
    .reverse_direction(reverse_direction), .local_control(local_control),
    .external_location_a(external_location_a), .external_location_b(external_location_b),
    .fault_reset_pulse(fault_reset_pulse), .run_disable(run_disable),
    .ramp_pair_two(ramp_pair_two), .ramp_output_zero(ramp_output_zero),
    .ramp_output_hold(ramp_output_hold), .ramp_input_zero(ramp_input_zero),
    .panel_local_lockout(panel_local_lockout),
    .second_torque_limit_select(second_torque_limit_select));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic xf(input logic [11:0] a, input logic wr, input logic [31:0] d);
    u_master.xfer(a, wr, d, q, ok);
    if (!ok)
    begin
      err_total++;
      $display("[FAIL] %0t bus wait ran out", $time);
      give_verdict();
    end
  endtask
  // main sequence: each bit alone, then start/stop and modes via status
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk(outs, 32'h0010);
    @(posedge hclk);
    xf(12'h000, 1'b0, 32'h0);
    chk(q, 32'h0);
    p = 16'h0000;
    // bit 4 comes twice so a held level must give no second pulse
    for (int i = 0; i < 17; i++)
    begin
      w = 16'h0001 << (i > 4 ? i - 1 : i);
      reference_sign <= i[0];
      panel_local_key <= i[1];
      xf(12'h000, 1'b1, {16'hffff, w});
      repeat (2) @(negedge hclk);
      e = {i > 0 && i < 7, 2'h0, w[15:10], w[6], w[5], !w[5],
        w[3] | (i[1] & !w[14]), w[2] ^ i[0], w[0], w[4] & !p[4]};
      chk(outs[15:10], e[15:10]);
      chk(outs[9:5], e[9:5]);
      chk(outs[4:0], e[4:0]);
      p = w;
      @(posedge hclk);
    end
    xf(12'h000, 1'b0, 32'h0);
    chk(q, 32'h8000);
    $display("test command bits done");
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7)
        xf(12'h008, 1'b1, 32'h3);
      xf(12'h000, 1'b1, {16'h0, tv[i][19:4]});
      @(posedge hclk);
      xf(12'h004, 1'b0, 32'h0);
      chk(q, {28'h0, tv[i][3:0]});
    end
    $display("test start stop done");
    xf(12'h00c, 1'b1, 32'hffff);
    xf(12'h00c, 1'b0, 32'h0);
    chk(q, 32'h0);
    xf(12'h008, 1'b0, 32'h0);
    chk(q, 32'h3);
    $display("test registers done");
    give_verdict();
  end
endmodule
bind drive_command_word_decoder cwd_sva u_sva (.*);
